// ---- logic/dma_channel_pointer_regs.sv ----
// Purpose: per-channel pointer, count and reload registers of a peripheral DMA
// Assumes: Avalon-MM slave with waitrequest, byte address, synchronous reset
// Notes:   partner pulses done or error once per item while request is high
`timescale 1ns/1ns
`default_nettype none
module dma_channel_pointer_regs #(
    parameter logic [31:0] PSELECT_INIT = dma_regs_pkg::PSELECT_RESET,
    parameter logic [31:0] VERSION_INIT = dma_regs_pkg::VERSION_RESET
) (
    input  wire logic                                clock,
    input  wire logic                                reset,
    input  wire logic [11:0]                         address,
    input  wire logic                                read,
    input  wire logic                                write,
    input  wire logic [31:0]                         writedata,
    input  wire logic [3:0]                          byteenable,
    output logic      [31:0]                         readdata,
    output logic                                     waitrequest,
    input  wire logic [dma_regs_pkg::CHANNELS-1:0]   xferDone,
    input  wire logic [dma_regs_pkg::CHANNELS-1:0]   xferError,
    output logic      [dma_regs_pkg::CHANNELS-1:0]   xferRequest,
    output logic      [31:0]                         memAddress [dma_regs_pkg::CHANNELS],
    output logic      [dma_regs_pkg::PID_WIDTH-1:0]  peripheralId [dma_regs_pkg::CHANNELS],
    output logic      [1:0]                          xferSize [dma_regs_pkg::CHANNELS],
    output logic                                     irq
);
    localparam int CH = dma_regs_pkg::CHANNELS;

    logic [31:0] pointer_reg [CH];
    logic [15:0] count_reg [CH];
    logic [31:0] ptrReload_reg [CH];
    logic [15:0] cntReload_reg [CH];
    logic [31:0] pselect_reg [CH];
    logic [1:0]  size_reg [CH];
    logic        ring_reg [CH];
    logic        enabled_reg [CH];
    logic        error_reg [CH];
    logic [2:0]  irqMask_reg [CH];
    logic [2:0]  irqFlags_reg [CH];
    logic [CH-1:0] request_reg;
    logic        irq_reg;
    logic        wait_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [11:0] chanIdx;
    logic [11:0] regOfs;
    logic        inChannel;
    logic        wrAcc;
    logic [CH-1:0] chanSel;
    logic [CH-1:0] doneOk;
    logic [CH-1:0] reloadNow;
    logic [31:0] step [CH];

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign chanIdx   = address / dma_regs_pkg::CHANNEL_STRIDE;
    assign regOfs    = address % dma_regs_pkg::CHANNEL_STRIDE;
    assign inChannel = chanIdx < 12'(CH);
    assign wrAcc     = write && !wait_reg;

    always_comb begin
        for (int i = 0; i < CH; i++) begin
            chanSel[i]   = inChannel && (chanIdx == 12'(i));
            doneOk[i]    = xferDone[i] && request_reg[i] && (count_reg[i] != 16'h0000);
            reloadNow[i] = (count_reg[i] == 16'h0000) && (cntReload_reg[i] != 16'h0000);
            case (size_reg[i])
                dma_regs_pkg::SIZE_BYTE: step[i] = dma_regs_pkg::STEP_BYTE;
                dma_regs_pkg::SIZE_HALF: step[i] = dma_regs_pkg::STEP_HALF;
                default:                 step[i] = dma_regs_pkg::STEP_WORD;
            endcase
        end
    end

    // pointer, count and their reload values
    always_ff @(posedge clock) begin
        for (int i = 0; i < CH; i++) begin
            if (reset) begin
                pointer_reg[i]   <= dma_regs_pkg::POINTER_RESET;
                count_reg[i]     <= dma_regs_pkg::COUNT_RESET;
                ptrReload_reg[i] <= dma_regs_pkg::WORD_RESET;
                cntReload_reg[i] <= dma_regs_pkg::COUNT_RESET;
            end else begin
                if (doneOk[i]) begin
                    pointer_reg[i] <= pointer_reg[i] + step[i];
                    count_reg[i]   <= count_reg[i] - 16'h0001;
                end else if (reloadNow[i]) begin
                    pointer_reg[i] <= ptrReload_reg[i];
                    count_reg[i]   <= cntReload_reg[i];
                    if (!ring_reg[i]) begin
                        ptrReload_reg[i] <= dma_regs_pkg::WORD_RESET;
                        cntReload_reg[i] <= dma_regs_pkg::COUNT_RESET;
                    end
                end
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_POINTER) begin
                    pointer_reg[i] <= mergeBytes(pointer_reg[i], writedata, byteenable);
                end
                // only the low half is stored
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_COUNT) begin
                    count_reg[i] <= 16'(mergeBytes({16'h0000, count_reg[i]}, writedata, byteenable));
                end
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_PTR_RELOAD) begin
                    ptrReload_reg[i] <= mergeBytes(ptrReload_reg[i], writedata, byteenable);
                end
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_CNT_RELOAD) begin
                    cntReload_reg[i] <= 16'(mergeBytes({16'h0000, cntReload_reg[i]}, writedata, byteenable));
                    if (count_reg[i] == 16'h0000 && !doneOk[i] &&
                        16'(mergeBytes({16'h0000, cntReload_reg[i]}, writedata, byteenable)) != 16'h0000) begin
                        count_reg[i]   <= 16'(mergeBytes({16'h0000, cntReload_reg[i]}, writedata, byteenable));
                        pointer_reg[i] <= ptrReload_reg[i];
                        if (!ring_reg[i]) begin
                            ptrReload_reg[i] <= dma_regs_pkg::WORD_RESET;
                            cntReload_reg[i] <= dma_regs_pkg::COUNT_RESET;
                        end
                    end
                end
            end
        end
    end

    // peripheral selection and mode
    always_ff @(posedge clock) begin
        for (int i = 0; i < CH; i++) begin
            if (reset) begin
                pselect_reg[i] <= PSELECT_INIT;
                size_reg[i]    <= dma_regs_pkg::SIZE_BYTE;
                ring_reg[i]    <= 1'b0;
            end else begin
                // identifier field from bit 0, width by build
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_PSELECT) begin
                    pselect_reg[i] <= mergeBytes(pselect_reg[i], writedata, byteenable)
                        & {{(32-dma_regs_pkg::PID_WIDTH){1'b0}}, {dma_regs_pkg::PID_WIDTH{1'b1}}};
                end
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_CONFIG) begin
                    size_reg[i] <= writedata[dma_regs_pkg::CFG_SIZE_LSB +: 2];
                    ring_reg[i] <= writedata[dma_regs_pkg::CFG_RING_BIT];
                end
            end
        end
    end

    // enable and error state
    always_ff @(posedge clock) begin
        for (int i = 0; i < CH; i++) begin
            if (reset) begin
                enabled_reg[i] <= 1'b0;
                error_reg[i]   <= 1'b0;
            end else begin
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_COMMAND) begin
                    if (writedata[dma_regs_pkg::CMD_DISABLE_BIT]) begin
                        enabled_reg[i] <= 1'b0;
                    end else if (writedata[dma_regs_pkg::CMD_ENABLE_BIT]) begin
                        enabled_reg[i] <= 1'b1;
                    end
                    if (writedata[dma_regs_pkg::CMD_ERRCLR_BIT]) begin
                        error_reg[i] <= 1'b0;
                    end
                end
                // a new error wins over a clear in the same cycle
                if (xferError[i] && request_reg[i]) begin
                    error_reg[i] <= 1'b1;
                end
            end
        end
    end

    // request while enabled, error free and items remain
    always_ff @(posedge clock) begin
        for (int i = 0; i < CH; i++) begin
            if (reset) begin
                request_reg[i] <= 1'b0;
            end else begin
                request_reg[i] <= enabled_reg[i] && !error_reg[i] && count_reg[i] != 16'h0000;
            end
        end
    end

    // sticky interrupt flags, mask and the shared line
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < CH; i++) begin
                irqMask_reg[i]  <= 3'h0;
                irqFlags_reg[i] <= 3'h0;
            end
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            for (int i = 0; i < CH; i++) begin
                if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_IRQ_SET) begin
                    irqMask_reg[i] <= irqMask_reg[i] | writedata[2:0];
                end else if (wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_IRQ_CLEAR) begin
                    irqMask_reg[i] <= irqMask_reg[i] & ~writedata[2:0];
                end
                irqFlags_reg[i] <= (irqFlags_reg[i] &
                    ~((wrAcc && chanSel[i] && regOfs == dma_regs_pkg::OFS_IRQ_FLAGS) ? writedata[2:0] : 3'h0))
                    | {xferError[i] && request_reg[i],
                       count_reg[i] == 16'h0000 && cntReload_reg[i] == 16'h0000,
                       cntReload_reg[i] == 16'h0000};
                if ((irqFlags_reg[i] & irqMask_reg[i]) != 3'h0) begin
                    irq_reg <= 1'b1;
                end
            end
        end
    end

    // read mux, unmapped words read as zero
    always_comb begin
        readdata_next = 32'h0000_0000;
        if (address == dma_regs_pkg::OFS_VERSION) begin
            readdata_next = VERSION_INIT;
        end else begin
            for (int i = 0; i < CH; i++) begin
                if (chanSel[i]) begin
                    case (regOfs)
                        dma_regs_pkg::OFS_POINTER:    readdata_next = pointer_reg[i];
                        dma_regs_pkg::OFS_PSELECT:    readdata_next = pselect_reg[i];
                        dma_regs_pkg::OFS_COUNT:      readdata_next = {16'h0000, count_reg[i]};
                        dma_regs_pkg::OFS_PTR_RELOAD: readdata_next = ptrReload_reg[i];
                        dma_regs_pkg::OFS_CNT_RELOAD: readdata_next = {16'h0000, cntReload_reg[i]};
                        dma_regs_pkg::OFS_CONFIG:     readdata_next = {28'h0, ring_reg[i], 1'b0, size_reg[i]};
                        dma_regs_pkg::OFS_STATE:      readdata_next = {31'h0, enabled_reg[i]};
                        dma_regs_pkg::OFS_IRQ_VIEW:   readdata_next = {29'h0, irqMask_reg[i]};
                        dma_regs_pkg::OFS_IRQ_FLAGS:  readdata_next = {29'h0, irqFlags_reg[i]};
                        default:                      readdata_next = 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // one wait cycle per access, then one ready cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_reg     <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((read || write) && wait_reg);
            if (read && wait_reg) begin
                readdata_reg <= readdata_next;
            end
        end
    end

    assign readdata    = readdata_reg;
    assign waitrequest = wait_reg;
    assign xferRequest = request_reg;
    assign irq         = irq_reg;
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            memAddress[i]   = pointer_reg[i];
            peripheralId[i] = pselect_reg[i][dma_regs_pkg::PID_WIDTH-1:0];
            xferSize[i]     = size_reg[i];
        end
    end

    property p_advance;
        @(posedge clock) disable iff (reset)
        doneOk[0] && !wrAcc |=> pointer_reg[0] == $past(pointer_reg[0]) + $past(step[0])
            && count_reg[0] == $past(count_reg[0]) - 16'h0001;
    endproperty
    a_advance: assert property (p_advance) else $error("pointer or count did not advance");

    property p_reload;
        @(posedge clock) disable iff (reset)
        reloadNow[0] && !doneOk[0] && !wrAcc |=> pointer_reg[0] == $past(ptrReload_reg[0])
            && count_reg[0] == $past(cntReload_reg[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("reload not copied");

    property p_clear;
        @(posedge clock) disable iff (reset)
        reloadNow[0] && !doneOk[0] && !wrAcc |=> (ring_reg[0] ? cntReload_reg[0] == $past(cntReload_reg[0])
            : (cntReload_reg[0] == 16'h0000 && ptrReload_reg[0] == 32'h0));
    endproperty
    a_clear: assert property (p_clear) else $error("reload registers wrong after reload");

    property p_halt;
        @(posedge clock) disable iff (reset)
        count_reg[0] == 16'h0000 && cntReload_reg[0] == 16'h0000 && !wrAcc
            |=> !request_reg[0] && $stable(pointer_reg[0]) && $stable(ptrReload_reg[0]);
    endproperty
    a_halt: assert property (p_halt) else $error("idle channel changed or requested");

    property p_start;
        @(posedge clock) disable iff (reset)
        wrAcc && chanSel[0] && regOfs == dma_regs_pkg::OFS_COUNT && byteenable == 4'hf
            && writedata[15:0] != 16'h0 && enabled_reg[0] && !error_reg[0] |=> ##1 request_reg[0];
    endproperty
    a_start: assert property (p_start) else $error("channel did not start");

    property p_immediate;
        @(posedge clock) disable iff (reset)
        wrAcc && chanSel[0] && regOfs == dma_regs_pkg::OFS_CNT_RELOAD && byteenable == 4'hf
            && count_reg[0] == 16'h0 && writedata[15:0] != 16'h0 |=> count_reg[0] == $past(writedata[15:0])
            && pointer_reg[0] == $past(ptrReload_reg[0]);
    endproperty
    a_immediate: assert property (p_immediate) else $error("idle reload write not loaded");

    property p_reloadwrite;
        @(posedge clock) disable iff (reset)
        wrAcc && chanSel[0] && regOfs == dma_regs_pkg::OFS_PTR_RELOAD && byteenable == 4'hf
            |=> ptrReload_reg[0] == $past(writedata);
    endproperty
    a_reloadwrite: assert property (p_reloadwrite) else $error("pointer reload write lost");

    property p_reset;
        @(posedge clock)
        reset |=> pointer_reg[0] == 32'h0 && count_reg[0] == 16'h0 && pselect_reg[0] == PSELECT_INIT;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_version;
        @(posedge clock) disable iff (reset)
        read && !wait_reg && address == dma_regs_pkg::OFS_VERSION |-> readdata == VERSION_INIT;
    endproperty
    a_version: assert property (p_version) else $error("version read wrong");

    property p_countread;
        @(posedge clock) disable iff (reset)
        read && wait_reg && chanSel[0] && regOfs == dma_regs_pkg::OFS_COUNT
            |=> !waitrequest && readdata == {16'h0, $past(count_reg[0])};
    endproperty
    a_countread: assert property (p_countread) else $error("count read wrong");
endmodule
`default_nettype wire

// ---- logic/dma_regs_pkg.sv ----
// Purpose: constants shared by the channel pointer register block
// Assumes: byte addressing, one 32-bit word per register
// Notes:   channel count and identifier width are fixed here
package dma_regs_pkg;
    localparam int          CHANNELS         = 2;
    localparam int          PID_WIDTH        = 6;
    localparam int          COUNT_WIDTH      = 16;
    localparam int          IRQ_WIDTH        = 3;
    localparam logic [11:0] CHANNEL_STRIDE   = 12'h040;
    localparam logic [11:0] OFS_POINTER      = 12'h000;
    localparam logic [11:0] OFS_PSELECT      = 12'h004;
    localparam logic [11:0] OFS_COUNT        = 12'h008;
    localparam logic [11:0] OFS_PTR_RELOAD   = 12'h00c;
    localparam logic [11:0] OFS_CNT_RELOAD   = 12'h010;
    localparam logic [11:0] OFS_COMMAND      = 12'h014;
    localparam logic [11:0] OFS_CONFIG       = 12'h018;
    localparam logic [11:0] OFS_STATE        = 12'h01c;
    localparam logic [11:0] OFS_IRQ_SET      = 12'h020;
    localparam logic [11:0] OFS_IRQ_CLEAR    = 12'h024;
    localparam logic [11:0] OFS_IRQ_VIEW     = 12'h028;
    localparam logic [11:0] OFS_IRQ_FLAGS    = 12'h02c;
    localparam logic [11:0] OFS_VERSION      = 12'h834;
    localparam int          CMD_ENABLE_BIT   = 0;
    localparam int          CMD_DISABLE_BIT  = 1;
    localparam int          CMD_ERRCLR_BIT   = 8;
    localparam int          CFG_SIZE_LSB     = 0;
    localparam int          CFG_RING_BIT     = 3;
    localparam int          STATE_ENABLE_BIT = 0;
    localparam int          IRQ_RCZ_BIT      = 0;
    localparam int          IRQ_TRC_BIT      = 1;
    localparam int          IRQ_TERR_BIT     = 2;
    localparam logic [1:0]  SIZE_BYTE        = 2'h0;
    localparam logic [1:0]  SIZE_HALF        = 2'h1;
    localparam logic [31:0] STEP_BYTE        = 32'h0000_0001;
    localparam logic [31:0] STEP_HALF        = 32'h0000_0002;
    localparam logic [31:0] STEP_WORD        = 32'h0000_0004;
    localparam logic [31:0] POINTER_RESET    = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
    // arbitrary defaults, the real ones are set per build
    localparam logic [31:0] PSELECT_RESET    = 32'h0000_0000;
    localparam logic [31:0] VERSION_RESET    = 32'h0000_0100;
endpackage

// ---- testbench/dma_memory_model.sv ----
// Purpose: memory side of the channel transfer link, answers each request with item pulses
// Assumes: one pulse per item, at least two cycles apart
// Notes:   stallOn stretches the gap, errorKick answers with an error pulse instead
`timescale 1ns/1ns
`default_nettype none
module dma_memory_model (
    input  wire logic                              clock,
    input  wire logic                              reset,
    input  wire logic [dma_regs_pkg::CHANNELS-1:0] xferRequest,
    input  wire logic                              stallOn,
    input  wire logic [dma_regs_pkg::CHANNELS-1:0] errorKick,
    output logic      [dma_regs_pkg::CHANNELS-1:0] xferDone,
    output logic      [dma_regs_pkg::CHANNELS-1:0] xferError
);
    logic [3:0] gapCount [dma_regs_pkg::CHANNELS];
    always_ff @(posedge clock) begin
        for (int i = 0; i < dma_regs_pkg::CHANNELS; i++) begin
            xferDone[i]  <= 1'b0;
            xferError[i] <= 1'b0;
            if (reset) begin
                gapCount[i] <= 4'h0;
            end else if (xferRequest[i] && !xferDone[i] && !xferError[i]) begin
                if (gapCount[i] == 4'h0) begin
                    xferError[i] <= errorKick[i];
                    xferDone[i]  <= !errorKick[i];
                    gapCount[i]  <= stallOn ? 4'h6 : 4'h0;
                end else begin
                    gapCount[i] <= gapCount[i] - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_dma_channel_pointer_regs.sv ----
// Purpose: self-checking bench for the channel pointer register block
// Assumes: register bus master holds each request until waitrequest is sampled low
// Notes:   channel 0 at base 0x000, channel 1 at base 0x040
`timescale 1ns/1ns
`default_nettype none
module test_dma_channel_pointer_regs;
    logic        clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, stallOn = 1'b0, irq, waitrequest;
    logic [11:0] address = 12'h000;
    logic [31:0] writedata = 32'h0, readdata, r;
    logic [3:0]  byteenable = 4'hf;
    logic [1:0]  xferDone, xferError, xferRequest, errorKick = 2'h0;
    logic [31:0] memAddress [2];
    logic [5:0]  peripheralId [2];
    logic [1:0]  xferSize [2];
    int          fail_count = 0, checks_done = 0, cycles = 0;
    always #20 clock = ~clock;
    dma_channel_pointer_regs u_dma_channel_pointer_regs (.clock(clock), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .xferDone(xferDone), .xferError(xferError), .xferRequest(xferRequest),
        .memAddress(memAddress), .peripheralId(peripheralId), .xferSize(xferSize), .irq(irq));
    dma_memory_model u_dma_memory_model (.clock(clock), .reset(reset), .xferRequest(xferRequest),
        .stallOn(stallOn), .errorKick(errorKick), .xferDone(xferDone), .xferError(xferError));
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic rd, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            fail_count++;
        end
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        access(1'b0, a, d);
    endtask
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        access(1'b1, a, 32'h0);
        check(what, r, exp);
    endtask
    task automatic waitIdle(input int ch);
        int quiet, n;
        quiet = 0;
        n = 0;
        while (quiet < 4 && n < 600) begin
            @(posedge clock);
            quiet = (xferRequest[ch] === 1'b0) ? quiet + 1 : 0;
            n++;
        end
        if (quiet < 4) begin
            fail_count++;
        end
    endtask
    task automatic resetValues();
        logic [31:0] expWord;
        for (int o = 0; o < 12; o++) begin
            expWord = (o == 1) ? (dma_regs_pkg::PSELECT_RESET & 32'h3f) : ((o == 11) ? 32'h3 : 32'h0);
            rdChk("reset word", 12'(o * 4), expWord);
        end
        rdChk("ch1 flags", 12'h06c, 32'h3);
        wr(dma_regs_pkg::OFS_VERSION, 32'h0);
        rdChk("version", dma_regs_pkg::OFS_VERSION, dma_regs_pkg::VERSION_RESET);
        rdChk("unmapped", 12'h030, 32'h0);
    endtask
    task automatic selectPeripheral();
        wr(dma_regs_pkg::OFS_PSELECT, 32'hffff_ffff);
        rdChk("select", dma_regs_pkg::OFS_PSELECT, 32'h3f);
        check("pid port", 32'(peripheralId[0]), 32'h3f);
    endtask
    task automatic stepSizes();
        for (int s = 0; s < 3; s++) begin
            wr(12'h058, 32'(s));
            wr(12'h040, 32'h1000);
            wr(12'h054, 32'h1);
            wr(12'h048, 32'h3);
            waitIdle(1);
            rdChk("pointer", 12'h040, 32'h1000 + 32'(3 << s));
            rdChk("count", 12'h048, 32'h0);
            check("mem port", memAddress[1], 32'h1000 + 32'(3 << s));
            check("size port", 32'(xferSize[1]), 32'(s));
        end
    endtask
    task automatic reloads();
        wr(dma_regs_pkg::OFS_PTR_RELOAD, 32'h2000);
        wr(dma_regs_pkg::OFS_CNT_RELOAD, 32'h5);
        rdChk("pointer", 12'h000, 32'h2000);
        rdChk("count", 12'h008, 32'h5);
        rdChk("ptr reload", 12'h00c, 32'h0);
        wr(dma_regs_pkg::OFS_PTR_RELOAD, 32'h3000);
        wr(dma_regs_pkg::OFS_CNT_RELOAD, 32'h4);
        rdChk("ptr reload", 12'h00c, 32'h3000);
        stallOn <= 1'b1;
        wr(dma_regs_pkg::OFS_COMMAND, 32'h1);
        // count rewritten while enabled; the reload still ends at the second buffer
        wr(dma_regs_pkg::OFS_COUNT, 32'h5);
        waitIdle(0);
        stallOn <= 1'b0;
        rdChk("pointer", 12'h000, 32'h3004);
        rdChk("cnt reload", 12'h010, 32'h0);
        rdChk("ptr reload", 12'h00c, 32'h0);
        check("request", 32'(xferRequest[0]), 32'h0);
        wr(dma_regs_pkg::OFS_CONFIG, 32'h8);
        wr(dma_regs_pkg::OFS_PTR_RELOAD, 32'h4000);
        wr(dma_regs_pkg::OFS_CNT_RELOAD, 32'h2);
        repeat (40) @(posedge clock);
        wr(dma_regs_pkg::OFS_COMMAND, 32'h2);
        rdChk("ring ptr", 12'h00c, 32'h4000);
        rdChk("ring cnt", 12'h010, 32'h2);
        rdChk("state", 12'h01c, 32'h0);
    endtask
    task automatic errorIrq();
        int n;
        wr(12'h058, 32'h0);
        wr(12'h060, 32'h4);
        rdChk("mask", 12'h068, 32'h4);
        errorKick <= 2'h2;
        wr(12'h048, 32'h3);
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        check("irq up", 32'(irq), 32'h1);
        access(1'b1, 12'h06c, 32'h0);
        check("err flag", r & 32'h4, 32'h4);
        check("stopped", 32'(xferRequest[1]), 32'h0);
        errorKick <= 2'h0;
        wr(12'h06c, 32'h4);
        repeat (2) @(posedge clock);
        check("irq down", 32'(irq), 32'h0);
        wr(12'h064, 32'h4);
        rdChk("mask", 12'h068, 32'h0);
        wr(12'h054, 32'h100);
        waitIdle(1);
        rdChk("count", 12'h048, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        resetValues();
        selectPeripheral();
        stepSizes();
        reloads();
        errorIrq();
        conclude();
    end
endmodule
`default_nettype wire
